// file: design/sewc_fifo.sv
// Small word FIFO between the page buffer and the array write port
module sewc_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic    sys_clk,
    input wire logic    rst,
    // Streams
    sewc_stream_if.snk  in_if,
    sewc_stream_if.src  out_if,
    // State
    output logic        empty
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("sewc_fifo depth must be a power of two of at least 2");
    end

    assign in_if.ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_if.valid = (count_ff != '0);
    assign out_if.data  = mem_ff[rd_ptr_ff];
    assign empty        = (count_ff == '0);
    assign push         = in_if.valid && in_if.ready;
    assign pop          = out_if.valid && out_if.ready;

    always_ff @(posedge sys_clk)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_if.data;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            if (push && !pop)
                count_ff <= count_ff + 1'b1;
            else if (pop && !push)
                count_ff <= count_ff - 1'b1;
        end
    end
endmodule : sewc_fifo

// file: design/sewc_top.sv
// Serial EEPROM write control: command decode, write latch, protection, page buffer and busy timing
`include "sewc_map.svh"

// How it works
// - Power-up leaves write latch cleared
// - Clear command disables all programming
// - Array programming needs protect pin high, latch
// - Protection bits refuse writes in range
// - Programming starts only at chip-select rise
// - Status bit 0 shows programming busy
// - While busy only status read accepted
// - Page holds up to four bytes
// - Only two low address bits increment
// - Extra bytes wrap and overwrite page
// - Array programming end clears latch
// - Latch clear: write discarded, back standby
// - Status write changes only protection bits
// - Status write needs protect pin, latch
// - Status write: opcode, one byte, rise
// - Status write end clears latch
// - Bad opcode: ignore until next select
// - Opcodes for set, clear and write
// - Opcode bit 3 is address bit 8
// - Sample input on falling clock, output on rising
// - Status bit 1 shows write latch
module sewc_top #(
    parameter int PROG_TIME_NS = `SEWC_PROG_TIME_NS,
    parameter int FIFO_DEPTH   = `SEWC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic              sys_clk,
    input wire logic              rst,
    // Serial pins
    input wire logic              cs_n,
    input wire logic              sck,
    input wire logic              si,
    input wire logic              wp_n,
    output logic                  so,
    output logic                  so_oe_n,
    // Array write port
    output logic                  arr_wr_valid,
    output logic [8:0]            arr_wr_addr,
    output sewc_pkg::sewc_byte_t  arr_wr_data,
    input wire logic              arr_wr_ready
);
    import sewc_pkg::*;

    localparam int PROG_CYCLES_RAW = (PROG_TIME_NS + `SEWC_CLK_PERIOD_NS - 1) / `SEWC_CLK_PERIOD_NS;
    localparam int PROG_CYCLES     = (PROG_CYCLES_RAW < 1) ? 1 : PROG_CYCLES_RAW;
    localparam int WORD_W          = $bits(sewc_word_s);

    if (PROG_TIME_NS < 1 || FIFO_DEPTH < 2)
    begin : g_bad_param
        $error("sewc_top needs a positive programming time and a FIFO of at least 2 words");
    end

    // Pin synchronisers: a change counts once stages 2 and 3 agree
    logic [3:0] pin_in;
    logic [3:0] pin_lvl_ff;
    logic [3:0] pin_agree;
    logic [3:0] pin_new;
    assign pin_in = {wp_n, si, sck, cs_n};

    for (genvar i = 0; i < 4; i++)
    begin : g_sync
        logic [`SEWC_SYNC_STAGES-1:0] sync_ff;
        always_ff @(posedge sys_clk or posedge rst)
        begin
            if (rst)
            begin
                sync_ff       <= '1;
                pin_lvl_ff[i] <= 1'b1;
            end
            else
            begin
                sync_ff <= {sync_ff[1:0], pin_in[i]};
                if (sync_ff[1] == sync_ff[2])
                    pin_lvl_ff[i] <= sync_ff[2];
            end
        end
        assign pin_agree[i] = (sync_ff[1] == sync_ff[2]);
        assign pin_new[i]   = sync_ff[2];
    end

    logic cs_lvl;
    logic si_lvl;
    logic wp_lvl;
    logic cs_fall;
    logic cs_rise;
    logic sck_fall;
    logic sck_rise;
    assign cs_lvl   = pin_lvl_ff[0];
    assign si_lvl   = pin_new[2];
    assign wp_lvl   = pin_lvl_ff[3];
    assign cs_fall  = cs_lvl && pin_agree[0] && !pin_new[0];
    assign cs_rise  = !cs_lvl && pin_agree[0] && pin_new[0];
    assign sck_fall = !cs_lvl && !cs_rise && pin_lvl_ff[1] && pin_agree[1] && !pin_new[1];
    assign sck_rise = !cs_lvl && !cs_rise && !pin_lvl_ff[1] && pin_agree[1] && pin_new[1];

    // Command state
    sewc_cmd_e  state_ff;
    logic [2:0] bit_cnt_ff;
    sewc_byte_t shift_ff;
    sewc_byte_t nxt_shift;
    logic       byte_done;
    logic       op_byte;
    logic       busy;
    logic       wen_ff;
    logic [1:0] bp_ff;
    logic [1:0] sr_data_ff;
    logic [8:0] addr_ff;
    logic [1:0] page_idx_ff;
    logic       have_data_ff;
    sewc_byte_t page_buf_ff [`SEWC_PAGE_BYTES];
    logic [`SEWC_PAGE_BYTES-1:0] page_vld_ff;

    assign nxt_shift = {shift_ff[6:0], si_lvl};
    assign byte_done = sck_fall && (bit_cnt_ff == 3'h7);
    assign op_byte   = byte_done && (state_ff == st_opcode);

    logic op_set;
    logic op_clr;
    logic op_rd;
    logic op_sr_wr;
    logic op_write;
    assign op_set   = (nxt_shift == `SEWC_OP_SET_WL);
    assign op_clr   = (nxt_shift == `SEWC_OP_CLR_WL);
    assign op_rd    = (nxt_shift == `SEWC_OP_STAT_RD);
    assign op_sr_wr = (nxt_shift == `SEWC_OP_STAT_WR);
    assign op_write = ((nxt_shift & `SEWC_OP_WRITE_MASK) == `SEWC_OP_WRITE);

    function automatic logic prot_hit(input logic [1:0] bp, input logic [8:0] addr);
        unique case (bp)
            `SEWC_BP_NONE:    prot_hit = 1'b0;
            `SEWC_BP_QUARTER: prot_hit = addr[8] && addr[7];
            `SEWC_BP_HALF:    prot_hit = addr[8];
            `SEWC_BP_ALL:     prot_hit = 1'b1;
        endcase
    endfunction : prot_hit

    // Chip-select rise at the only permitted points
    logic arr_start;
    logic sr_start;
    assign arr_start = cs_rise && !busy && (state_ff == st_data) && (bit_cnt_ff == 3'h0) && have_data_ff
                       && wen_ff && wp_lvl && !prot_hit(bp_ff, addr_ff);
    assign sr_start  = cs_rise && !busy && (state_ff == st_sr_done) && wen_ff && wp_lvl;

    // Serial bit counter and shifter, sampled on falling clock
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            bit_cnt_ff <= '0;
            shift_ff   <= '0;
        end
        else if (cs_fall || cs_rise)
            bit_cnt_ff <= '0;
        else if (sck_fall && state_ff != st_ignore && state_ff != st_stat_out)
        begin
            bit_cnt_ff <= bit_cnt_ff + 1'b1;
            shift_ff   <= nxt_shift;
        end
    end

    // Command decoder
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            state_ff <= st_opcode;
        else if (cs_fall || cs_rise)
            state_ff <= st_opcode;
        else if (op_byte)
        begin
            if (busy)
                state_ff <= op_rd ? st_stat_out : st_ignore;
            else if (op_rd)
                state_ff <= st_stat_out;
            else if (op_sr_wr)
                state_ff <= st_sr_data;
            else if (op_write)
                state_ff <= st_addr;
            else
                state_ff <= st_ignore;
        end
        else if (byte_done && state_ff == st_addr)
            state_ff <= st_data;
        else if (byte_done && state_ff == st_sr_data)
            state_ff <= st_sr_done;
        else if (sck_fall && state_ff == st_sr_done)
            state_ff <= st_ignore;
    end

    // Address, page buffer and status write data
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            addr_ff      <= '0;
            page_idx_ff  <= '0;
            have_data_ff <= 1'b0;
            page_vld_ff  <= '0;
            sr_data_ff   <= '0;
        end
        else if (op_byte && !busy && op_write)
        begin
            addr_ff[8]   <= nxt_shift[`SEWC_OP_A8_BIT];
            have_data_ff <= 1'b0;
            page_vld_ff  <= '0;
        end
        else if (byte_done && state_ff == st_addr)
        begin
            addr_ff[7:0] <= nxt_shift;
            page_idx_ff  <= nxt_shift[1:0];
        end
        else if (byte_done && state_ff == st_data)
        begin
            page_vld_ff[page_idx_ff] <= 1'b1;
            page_idx_ff  <= page_idx_ff + 1'b1;
            have_data_ff <= 1'b1;
        end
        else if (byte_done && state_ff == st_sr_data)
            sr_data_ff <= nxt_shift[`SEWC_ST_BP_HI_BIT:`SEWC_ST_BP_LO_BIT];
    end

    always_ff @(posedge sys_clk)
    begin
        if (byte_done && state_ff == st_data)
            page_buf_ff[page_idx_ff] <= nxt_shift;
    end

    // Programming sequencer; the FIFO lets a slow array stall the push
    sewc_prog_e prog_ff;
    logic       prog_sr_ff;
    logic [1:0] push_idx_ff;
    logic [31:0] timer_ff;
    logic       fifo_empty;
    logic       prog_done;
    sewc_word_s push_word;

    sewc_stream_if #(.WIDTH(WORD_W)) push_if ();
    sewc_stream_if #(.WIDTH(WORD_W)) pop_if ();

    assign busy          = (prog_ff != pg_idle);
    assign push_word     = '{addr: {addr_ff[8:2], push_idx_ff}, data: page_buf_ff[push_idx_ff]};
    assign push_if.valid = (prog_ff == pg_push) && page_vld_ff[push_idx_ff];
    assign push_if.data  = push_word;
    assign prog_done     = (prog_ff == pg_wait) && (timer_ff == '0) && fifo_empty;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prog_ff     <= pg_idle;
            prog_sr_ff  <= 1'b0;
            push_idx_ff <= '0;
            timer_ff    <= '0;
        end
        else
        begin
            unique case (prog_ff)
                pg_idle:
                begin
                    push_idx_ff <= '0;
                    timer_ff    <= 32'(PROG_CYCLES - 1);
                    if (arr_start)
                    begin
                        prog_ff    <= pg_push;
                        prog_sr_ff <= 1'b0;
                    end
                    else if (sr_start)
                    begin
                        prog_ff    <= pg_wait;
                        prog_sr_ff <= 1'b1;
                    end
                end
                pg_push:
                begin
                    if (timer_ff != '0)
                        timer_ff <= timer_ff - 1'b1;
                    if (!push_if.valid || push_if.ready)
                    begin
                        push_idx_ff <= push_idx_ff + 1'b1;
                        if (push_idx_ff == 2'h3)
                            prog_ff <= pg_wait;
                    end
                end
                pg_wait:
                begin
                    if (timer_ff != '0)
                        timer_ff <= timer_ff - 1'b1;
                    if (prog_done)
                        prog_ff <= pg_idle;
                end
                default:
                    prog_ff <= pg_idle;
            endcase
        end
    end

    sewc_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk (sys_clk),
        .rst     (rst),
        .in_if   (push_if),
        .out_if  (pop_if),
        .empty   (fifo_empty)
    );

    sewc_word_s pop_word;
    assign pop_word     = pop_if.data;
    assign arr_wr_valid = pop_if.valid;
    assign arr_wr_addr  = pop_word.addr;
    assign arr_wr_data  = pop_word.data;
    assign pop_if.ready = arr_wr_ready;

    // Write latch; power-up value is cleared
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            wen_ff <= 1'b0;
        else if (prog_done)
            wen_ff <= 1'b0;
        else if (op_byte && !busy && op_clr)
            wen_ff <= 1'b0;
        else if (op_byte && !busy && op_set)
            wen_ff <= 1'b1;
    end

    // Protection level, updated when the status write completes
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            bp_ff <= `SEWC_BP_NONE;
        else if (prog_done && prog_sr_ff)
            bp_ff <= sr_data_ff;
    end

    // Status read out, driven after rising clock edges
    sewc_byte_t status;
    sewc_byte_t out_sr_ff;
    logic [2:0] out_cnt_ff;
    assign status = {`SEWC_ST_UPPER, bp_ff, wen_ff, busy};

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            out_sr_ff  <= '0;
            out_cnt_ff <= '0;
            so         <= 1'b1;
            so_oe_n    <= 1'b1;
        end
        else if (cs_fall || cs_rise)
            so_oe_n <= 1'b1;
        else if (op_byte && op_rd)
        begin
            out_sr_ff  <= status;
            out_cnt_ff <= '0;
        end
        else if (sck_rise && state_ff == st_stat_out)
        begin
            so         <= out_sr_ff[7];
            so_oe_n    <= 1'b0;
            out_cnt_ff <= out_cnt_ff + 1'b1;
            out_sr_ff  <= (out_cnt_ff == 3'h7) ? status : {out_sr_ff[6:0], 1'b0};
        end
    end

    // Checks
    sequence s_sr_finish;
        prog_done && prog_sr_ff;
    endsequence

    property p_clr_latch;
        @(posedge sys_clk) disable iff (rst) (op_byte && !busy && op_clr) |=> !wen_ff;
    endproperty
    a_clr_latch: assert property (p_clr_latch) else $error("latch still set after clear command");

    property p_arr_guard;
        @(posedge sys_clk) disable iff (rst)
            (prog_ff == pg_idle ##1 prog_ff == pg_push) |-> $past(wen_ff) && $past(wp_lvl) && $past(cs_rise);
    endproperty
    a_arr_guard: assert property (p_arr_guard) else $error("array programming started without permission");

    property p_prot;
        @(posedge sys_clk) disable iff (rst) push_if.valid |-> !prot_hit(bp_ff, push_word.addr);
    endproperty
    a_prot: assert property (p_prot) else $error("protected address pushed for programming");

    property p_busy_bit;
        @(posedge sys_clk) disable iff (rst) (arr_start || sr_start) |=> status[`SEWC_ST_BUSY_BIT] [*2];
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit low during programming");

    property p_busy_reject;
        @(posedge sys_clk) disable iff (rst) (op_byte && busy && !op_rd) |=> state_ff == st_ignore;
    endproperty
    a_busy_reject: assert property (p_busy_reject) else $error("command taken while busy");

    property p_page_wrap;
        @(posedge sys_clk) disable iff (rst)
            (byte_done && state_ff == st_data && !cs_fall) |=> page_idx_ff == $past(page_idx_ff) + 2'h1;
    endproperty
    a_page_wrap: assert property (p_page_wrap) else $error("page index did not advance by one");

    property p_done_clears;
        @(posedge sys_clk) disable iff (rst) prog_done |=> !wen_ff && !busy;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("latch not cleared at end of programming");

    property p_sr_update;
        @(posedge sys_clk) disable iff (rst) s_sr_finish |=> bp_ff == $past(sr_data_ff) && !wen_ff;
    endproperty
    a_sr_update: assert property (p_sr_update) else $error("status write did not land");

    property p_invalid_quiet;
        @(posedge sys_clk) disable iff (rst)
            (op_byte && !busy && !op_set && !op_clr && !op_rd && !op_sr_wr && !op_write) |=> so_oe_n [*3];
    endproperty
    a_invalid_quiet: assert property (p_invalid_quiet) else $error("output driven after bad opcode");

    property p_wen_bit;
        @(posedge sys_clk) disable iff (rst) (op_byte && !busy && op_set) |=> status[`SEWC_ST_WEN_BIT];
    endproperty
    a_wen_bit: assert property (p_wen_bit) else $error("status latch bit not set");
endmodule : sewc_top

// file: inc/sewc_map.svh
// Opcodes, status bit positions, protection bases and timing figures of the write-control block
`ifndef SEWC_MAP_SVH
`define SEWC_MAP_SVH

`define SEWC_OP_SET_WL      8'h06
`define SEWC_OP_CLR_WL      8'h04
`define SEWC_OP_STAT_RD     8'h05
`define SEWC_OP_STAT_WR     8'h01
`define SEWC_OP_WRITE       8'h02
`define SEWC_OP_WRITE_MASK  8'hf7
`define SEWC_OP_A8_BIT      3

`define SEWC_ST_BUSY_BIT    0
`define SEWC_ST_WEN_BIT     1
`define SEWC_ST_BP_LO_BIT   2
`define SEWC_ST_BP_HI_BIT   3
`define SEWC_ST_UPPER       4'h0

`define SEWC_BP_NONE        2'h0
`define SEWC_BP_QUARTER     2'h1
`define SEWC_BP_HALF        2'h2
`define SEWC_BP_ALL         2'h3

`define SEWC_PAGE_BYTES     4
`define SEWC_FIFO_DEPTH     4
`define SEWC_SYNC_STAGES    3
`define SEWC_CLK_PERIOD_NS  20
`define SEWC_PROG_TIME_NS   5000

`endif

// file: inc/sewc_pkg.sv
// Types shared by the write-control block
package sewc_pkg;

    typedef enum logic [2:0] {
        st_opcode,
        st_addr,
        st_data,
        st_sr_data,
        st_sr_done,
        st_stat_out,
        st_ignore
    } sewc_cmd_e;

    typedef enum logic [1:0] {
        pg_idle,
        pg_push,
        pg_wait
    } sewc_prog_e;

    typedef struct packed {
        logic [8:0] addr;
        logic [7:0] data;
    } sewc_word_s;

    typedef logic [7:0] sewc_byte_t;

endpackage : sewc_pkg

// file: inc/sewc_stream_if.sv
// Valid/ready word stream between the write-control modules
interface sewc_stream_if #(
    parameter int WIDTH = 17
) ();
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sewc_stream_if

// file: testbench/serial_eeprom_write_control_bench.sv
// Self-checking bench of the serial EEPROM write control
`include "sewc_map.svh"
module serial_eeprom_write_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sewc_pkg::*;
    logic       sys_clk, rst, wp_n, so, so_oe_n, flip, cs_n, sck, si;
    logic       arr_wr_valid, arr_wr_ready;
    logic [8:0] arr_wr_addr;
    sewc_byte_t arr_wr_data;
    logic [15:0] lfsr, stall;
    int         mismatches, samples_checked, poll_n;
    sewc_byte_t got[int], expd[int];
    // A released line wobbles so stale data never reads as valid
    wire logic  so_line = (so_oe_n === 1'b0) ? so : flip;
    sewc_top #(.PROG_TIME_NS(10000)) i_sewc_top (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .sck(sck),
        .si(si), .wp_n(wp_n), .so(so), .so_oe_n(so_oe_n), .arr_wr_valid(arr_wr_valid),
        .arr_wr_addr(arr_wr_addr), .arr_wr_data(arr_wr_data), .arr_wr_ready(arr_wr_ready));
    sewc_spi_master i_sewc_spi_master (.sck(sck), .cs_n(cs_n), .si(si), .so_line(so_line),
        .so_oe_n(so_oe_n));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    function automatic logic [15:0] sewc_step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : sewc_step
    function automatic sewc_byte_t rnd();
        lfsr = sewc_step(lfsr);
        return lfsr[7:0];
    endfunction : rnd
    // Random stalls on the array side; capture each accepted word
    always @(posedge sys_clk)
    begin
        if (arr_wr_valid === 1'b1 && arr_wr_ready === 1'b1)
            got[arr_wr_addr] = arr_wr_data;
        flip <= ~flip;
        #1;
        stall = sewc_step(stall);
        arr_wr_ready = stall[0];
    end
    function automatic bit open_at(input int lvl, input logic [8:0] a);
        return lvl == 0 || (lvl == 1 && a < 9'h180) || (lvl == 2 && a < 9'h100);
    endfunction : open_at
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        samples_checked++;
        if (exp !== seen)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic frame(input sewc_byte_t q[$], input int last_bits);
        i_sewc_spi_master.select();
        foreach (q[k])
            i_sewc_spi_master.shift(q[k], (k == q.size() - 1) ? last_bits : 8);
        i_sewc_spi_master.deselect();
    endtask : frame
    task automatic rd_check(input sewc_byte_t exp);
        frame({`SEWC_OP_STAT_RD, 8'h00}, 8);
        check("status", exp, i_sewc_spi_master.rx);
    endtask : rd_check
    task automatic poll();
        poll_n = 0;
        do
        begin
            frame({`SEWC_OP_STAT_RD, 8'h00}, 8);
            poll_n++;
        end
        while (i_sewc_spi_master.rx[`SEWC_ST_BUSY_BIT] !== 1'b0 && poll_n < 40);
        check("busy", 16'h0, i_sewc_spi_master.rx[`SEWC_ST_BUSY_BIT]);
    endtask : poll
    task automatic wr_start(input logic [8:0] a, input sewc_byte_t d[$], input bit en, input int bits);
        logic [8:0] s;
        got.delete();
        expd.delete();
        for (int k = 0; k < d.size() && en; k++)
        begin
            s = {a[8:2], a[1:0] + 2'(k)};
            expd[s] = d[k];
        end
        d.push_front(a[7:0]);
        d.push_front(`SEWC_OP_WRITE | {4'h0, a[8], 3'h0});
        frame(d, bits);
        check("oe", 16'h0, i_sewc_spi_master.drove);
    endtask : wr_start
    task automatic wr_done();
        poll();
        check("count", 16'(expd.num()), 16'(got.num()));
        foreach (expd[s])
            check("byte", expd[s], got.exists(s) ? got[s] : 16'hffff);
        if (expd.num() > 0)
            check("latch", 16'h0, i_sewc_spi_master.rx[`SEWC_ST_WEN_BIT]);
    endtask : wr_done
    task automatic finish_test();
        if (mismatches == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : finish_test
    // Long enough for all programming windows with slack
    initial
    begin
        #1_800_000;
        mismatches++;
        finish_test();
    end
    initial
    begin
        sewc_byte_t b;
        sewc_byte_t d[$];
        logic [8:0] a;
        logic [8:0] tap[6];
        rst = 1'b1;
        tap = '{9'h000, 9'h0ff, 9'h100, 9'h17f, 9'h180, 9'h1ff};
        wp_n = 1'b1;
        flip = 1'b0;
        arr_wr_ready = 1'b0;
        lfsr = 16'hd628;
        stall = 16'hd628;
        mismatches = 0;
        samples_checked = 0;
        repeat (5) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        rd_check(8'h00);
        wr_start(9'h010, {8'h11}, 1'b0, 8);
        wr_done();
        frame({`SEWC_OP_SET_WL}, 8);
        rd_check(8'h02);
        frame({`SEWC_OP_CLR_WL}, 8);
        rd_check(8'h00);
        wr_start(9'h020, {8'h22}, 1'b0, 8);
        wr_done();
        frame({`SEWC_OP_SET_WL}, 8);
        wp_n = 1'b0;
        wr_start(9'h030, {8'h33}, 1'b0, 8);
        wr_done();
        frame({`SEWC_OP_STAT_WR, 8'h0c}, 8);
        rd_check(8'h02);
        wp_n = 1'b1;
        wr_start(9'h031, {8'h44, 8'h55, 8'h66}, 1'b0, 4);
        wr_done();
        frame({8'hff, `SEWC_OP_STAT_RD, 8'h00}, 8);
        check("oe", 16'h0, i_sewc_spi_master.drove);
        for (int n = 1; n <= 6; n += 5)
        begin
            a = {rnd(), 1'b0} ^ 9'(rnd());
            d.delete();
            repeat (n) d.push_back(rnd());
            frame({`SEWC_OP_SET_WL}, 8);
            wr_start(a, d, 1'b1, 8);
            wr_done();
        end
        // A write sent while busy must be dropped
        frame({`SEWC_OP_SET_WL}, 8);
        wr_start(9'h155, {8'h5a}, 1'b1, 8);
        frame({`SEWC_OP_STAT_RD, 8'h00}, 8);
        check("busy", 16'h1, i_sewc_spi_master.rx[`SEWC_ST_BUSY_BIT]);
        frame({`SEWC_OP_WRITE, 8'h77, 8'h99}, 8);
        wr_done();
        for (int lvl = 3; lvl >= 0; lvl--)
        begin
            frame({`SEWC_OP_SET_WL}, 8);
            b = rnd();
            b[3:2] = 2'(lvl);
            frame({`SEWC_OP_STAT_WR, b}, 8);
            poll();
            rd_check({4'h0, 2'(lvl), 2'b00});
            foreach (tap[t])
            begin
                frame({`SEWC_OP_SET_WL}, 8);
                wr_start(tap[t], {rnd()}, open_at(lvl, tap[t]), 8);
                wr_done();
            end
        end
        frame({`SEWC_OP_STAT_WR, 8'h0c}, 8);
        rd_check(8'h00);
        finish_test();
    end
endmodule : serial_eeprom_write_control_bench

// file: testbench/sewc_spi_master.sv
// SPI master model driving the serial pins of the write-control block
module sewc_spi_master (
    // Serial pins
    output logic     sck,
    output logic     cs_n,
    output logic     si,
    // Resolved data line
    input wire logic so_line,
    input wire logic so_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] rx;
    logic       drove;
    initial
    begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        rx = 8'h00;
        drove = 1'b0;
    end
    // Clock stays low outside frames
    task automatic select();
        drove = 1'b0;
        cs_n = 1'b0;
        #80;
    endtask : select
    // Read so late in the low phase, where it has settled
    task automatic shift(input logic [7:0] b, input int n);
        for (int i = 7; i > 7 - n; i--)
        begin
            si = b[i];
            sck = 1'b1;
            #80;
            sck = 1'b0;
            #80;
            rx = {rx[6:0], so_line};
            if (so_oe_n === 1'b0)
                drove = 1'b1;
        end
    endtask : shift
    // Rise while the clock is low after the last bit
    task automatic deselect();
        cs_n = 1'b1;
        si = ~si;
        #400;
    endtask : deselect
endmodule : sewc_spi_master
